// File: design/shared_gpio_ports.sv
// shared gpio ports b to e with register port, pin muxing and alternate functions
// Operation
// RL1 - analog b/d bits undriven, read 0 or latch
// RL2 - analog port d pins ignore dir_d for drive
// RL3 - five port c latches, untouched by reset
// RL4 - dir_c enables port c drivers, reset clears
// RL5 - port c read: latch if output, else pin
// RL6 - latch writes accepted whatever the direction
// RL7 - bus_clk_out_en drives bus clock on pin_c2
// RL8 - clock mode: bit 2 reads latch
// RL9 - seven port d latches and direction bits
// RL10 - port d read: latch, pin, or analog zero
// RL11 - pin_d6 feeds timer_ext_clk when selected
// RL12 - software avoids channel 14 with timer clock
// RL13 - eight port e latches with directions
// RL14 - spi_on gives pin e7 to spi clock
// RL15 - spi_on gives pin e6 to mosi
// RL16 - software writes latch before setting direction
// RL17 - converter_chan_sel picks the analog pin
// RL18 - port e read: latch if output, else pin
// RL19 - unimplemented c/d bits ignore writes, read 0
// RL20 - pin levels synchronised before being read
//
// Design decision made here: the address-and-strobe port.
`timescale 1ns/100ps
`include "gpio_defines.svh"
module shared_gpio_ports
    import gpio_pkg::*;
(
    input  wire logic       sys_clk_i,
    input  wire logic       rst_n_i,
    input  wire logic [7:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    input  wire logic [7:0] pin_b_i,
    output logic      [7:0] pin_b_o,
    output logic      [7:0] pin_b_oe_n_o,
    input  wire logic [4:0] pin_c_i,
    output logic      [4:0] pin_c_o,
    output logic      [4:0] pin_c_oe_n_o,
    input  wire logic [6:0] pin_d_i,
    output logic      [6:0] pin_d_o,
    output logic      [6:0] pin_d_oe_n_o,
    input  wire logic [7:0] pin_e_i,
    output logic      [7:0] pin_e_o,
    output logic      [7:0] pin_e_oe_n_o,
    input  wire logic       bus_clk_en_i,
    input  wire logic [2:0] timer_prescale_sel_i,
    input  wire logic       spi_on_i,
    input  wire logic       spi_master_i,
    input  wire logic       spi_sck_out_i,
    input  wire logic       spi_mosi_out_i,
    output logic            spi_clock_pin_o,
    output logic            spi_mosi_in_o,
    output logic            timer_ext_clk_o,
    output logic            timer_ext_sel_o
);
    // ==========================================================
    // registers
    byte_t      lat_b_q, lat_b_d, lat_c_q, lat_c_d, lat_d_q, lat_d_d, lat_e_q, lat_e_d;
    byte_t      dir_b_q, dir_b_d, dir_c_q, dir_c_d, dir_d_q, dir_d_d, dir_e_q, dir_e_d;
    logic [4:0] converter_chan_sel_q, converter_chan_sel_d;
    byte_t      rdata_q, rdata_d;
    logic       bus_clk_q, bus_clk_d;

    // latches carry no reset: their value is software's to set before driving
    always_comb begin
        lat_b_d = lat_b_q;
        lat_c_d = lat_c_q;
        lat_d_d = lat_d_q;
        lat_e_d = lat_e_q;
        if (wr_i) begin
            unique case (addr_i)
                `OFF_PORT_B_LATCH: lat_b_d = wdata_i;                 // [RL6]
                `OFF_PORT_C_LATCH: lat_c_d = wdata_i & `PORT_C_MASK;  // [RL3] [RL19]
                `OFF_PORT_D_LATCH: lat_d_d = wdata_i & `PORT_D_MASK;  // [RL9] [RL19]
                `OFF_PORT_E_LATCH: lat_e_d = wdata_i;                 // [RL13]
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        lat_b_q <= lat_b_d;
        lat_c_q <= lat_c_d;   // [RL3]
        lat_d_q <= lat_d_d;
        lat_e_q <= lat_e_d;
    end

    always_comb begin
        dir_b_d = dir_b_q;
        dir_c_d = dir_c_q;
        dir_d_d = dir_d_q;
        dir_e_d = dir_e_q;
        converter_chan_sel_d = converter_chan_sel_q;
        if (wr_i) begin
            unique case (addr_i)
                `OFF_DIR_B: dir_b_d = wdata_i;
                `OFF_DIR_C: dir_c_d = wdata_i & `DIR_C_MASK;   // [RL4] [RL7] [RL19]
                `OFF_DIR_D: dir_d_d = wdata_i & `PORT_D_MASK;  // [RL9] [RL19]
                `OFF_DIR_E: dir_e_d = wdata_i;                 // [RL13]
                `OFF_CTRL:  converter_chan_sel_d = wdata_i[4:0]; // [RL17]
                default: ;
            endcase
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dir_b_q <= 8'h00;
            dir_c_q <= 8'h00;   // [RL4] [RL7]
            dir_d_q <= 8'h00;   // [RL9]
            dir_e_q <= 8'h00;
            converter_chan_sel_q <= `CHAN_SEL_NONE;
        end else begin
            dir_b_q <= dir_b_d;
            dir_c_q <= dir_c_d;
            dir_d_q <= dir_d_d;
            dir_e_q <= dir_e_d;
            converter_chan_sel_q <= converter_chan_sel_d;
        end
    end

    // ==========================================================
    // pin sampling
    logic [7:0] sb, se;
    logic [4:0] sc;
    logic [6:0] sd;
    pin_sync #(.W(8)) u_sync_b (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .async_i(pin_b_i), .sync_o(sb)); // [RL20]
    pin_sync #(.W(5)) u_sync_c (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .async_i(pin_c_i), .sync_o(sc)); // [RL20]
    pin_sync #(.W(7)) u_sync_d (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .async_i(pin_d_i), .sync_o(sd)); // [RL20]
    pin_sync #(.W(8)) u_sync_e (.sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .async_i(pin_e_i), .sync_o(se)); // [RL20]

    // ==========================================================
    // converter ownership: one channel at a time, b is 0..7, d is 8..14
    logic [7:0] ana_b;
    logic [6:0] ana_d;
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            ana_b[i] = (converter_chan_sel_q == 5'(i));                     // [RL17]
        end
        for (int i = 0; i < 7; i++) begin
            ana_d[i] = (converter_chan_sel_q == 5'(i + 8));                 // [RL17]
        end
    end

    // ==========================================================
    // per-port selection
    logic [7:0] rd_b, drv_b, rd_e, drv_e;
    logic [4:0] rd_c, drv_c;
    logic [6:0] rd_d, drv_d;
    port_bit_mux #(.W(8)) u_mux_b (.latch_i(lat_b_q), .dir_i(dir_b_q), .pin_i(sb),
        .analog_i(ana_b), .rd_o(rd_b), .drive_o(drv_b));                   // [RL1]
    port_bit_mux #(.W(5)) u_mux_c (.latch_i(lat_c_q[4:0]), .dir_i(dir_c_q[4:0]), .pin_i(sc),
        .analog_i(5'h00), .rd_o(rd_c), .drive_o(drv_c));                   // [RL4] [RL5]
    port_bit_mux #(.W(7)) u_mux_d (.latch_i(lat_d_q[6:0]), .dir_i(dir_d_q[6:0]), .pin_i(sd),
        .analog_i(ana_d), .rd_o(rd_d), .drive_o(drv_d));                   // [RL1] [RL2] [RL10]
    port_bit_mux #(.W(8)) u_mux_e (.latch_i(lat_e_q), .dir_i(dir_e_q), .pin_i(se),
        .analog_i(8'h00), .rd_o(rd_e), .drive_o(drv_e));                   // [RL13] [RL18]

    logic clk_mode;
    assign clk_mode = dir_c_q[`BUS_CLK_OUT_BIT];

    // ==========================================================
    // read data, valid the cycle after the strobe
    always_comb begin
        rdata_d = 8'h00;
        if (rd_i) begin
            unique case (addr_i)
                `OFF_PORT_B_LATCH: rdata_d = rd_b;                          // [RL1]
                `OFF_PORT_C_LATCH: begin
                    rdata_d = {3'h0, rd_c};                                 // [RL5] [RL19]
                    if (clk_mode) rdata_d[`PIN_C2] = lat_c_q[`PIN_C2];     // [RL8]
                end
                `OFF_PORT_D_LATCH: rdata_d = {1'b0, rd_d};                  // [RL10] [RL19]
                `OFF_PORT_E_LATCH: rdata_d = rd_e;                          // [RL18]
                `OFF_DIR_B:        rdata_d = dir_b_q;
                `OFF_DIR_C:        rdata_d = dir_c_q;
                `OFF_DIR_D:        rdata_d = dir_d_q;
                `OFF_DIR_E:        rdata_d = dir_e_q;
                `OFF_CTRL:         rdata_d = {3'h0, converter_chan_sel_q};
                default:           rdata_d = 8'h00;
            endcase
        end
    end

    // ==========================================================
    // pin drive, registered; oe is low while driving
    byte_t      pb_o_q, pb_oe_q, pe_o_q, pe_oe_q;
    logic [4:0] pc_o_q, pc_oe_q;
    logic [6:0] pd_o_q, pd_oe_q;
    logic       sck_q, mosi_q, timer_ext_clk_q, tsel_q;
    byte_t      pe_o_d, pe_oe_d;
    logic [4:0] pc_o_d, pc_oe_d;

    // bus clock is the 125 MHz clock halved: a full-rate copy cannot leave a flop
    assign bus_clk_d = bus_clk_en_i ? ~bus_clk_q : 1'b0;

    always_comb begin
        pc_o_d  = lat_c_q[4:0];
        pc_oe_d = ~drv_c;                                                   // [RL4]
        if (clk_mode) begin
            pc_o_d[`PIN_C2]  = bus_clk_d;                                   // [RL7]
            pc_oe_d[`PIN_C2] = 1'b0;                                        // [RL8]
        end
        pe_o_d  = lat_e_q;
        pe_oe_d = ~drv_e;                                                   // [RL13]
        if (spi_on_i) begin
            pe_o_d[`PIN_E_SCK]   = spi_sck_out_i;                           // [RL14]
            pe_oe_d[`PIN_E_SCK]  = ~spi_master_i;                           // [RL14]
            pe_o_d[`PIN_E_MOSI]  = spi_mosi_out_i;                          // [RL15]
            pe_oe_d[`PIN_E_MOSI] = ~spi_master_i;                           // [RL15]
        end
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_q   <= 8'h00;
            bus_clk_q <= 1'b0;
            pb_o_q    <= 8'h00;
            pb_oe_q   <= 8'hff;
            pc_o_q    <= 5'h00;
            pc_oe_q   <= 5'h1f;
            pd_o_q    <= 7'h00;
            pd_oe_q   <= 7'h7f;
            pe_o_q    <= 8'h00;
            pe_oe_q   <= 8'hff;
            sck_q     <= 1'b0;
            mosi_q    <= 1'b0;
            timer_ext_clk_q    <= 1'b0;
            tsel_q    <= 1'b0;
        end else begin
            rdata_q   <= rdata_d;
            bus_clk_q <= bus_clk_d;
            pb_o_q    <= lat_b_q;
            pb_oe_q   <= ~drv_b;                                            // [RL1]
            pc_o_q    <= pc_o_d;
            pc_oe_q   <= pc_oe_d;
            pd_o_q    <= lat_d_q[6:0];
            pd_oe_q   <= ~drv_d;                                            // [RL2]
            pe_o_q    <= pe_o_d;
            pe_oe_q   <= pe_oe_d;
            sck_q     <= se[`PIN_E_SCK] & spi_on_i;                          // [RL14]
            mosi_q    <= se[`PIN_E_MOSI] & spi_on_i;                         // [RL15]
            timer_ext_clk_q    <= sd[`PIN_D6] & (timer_prescale_sel_i == `PRESCALE_EXT); // [RL11]
            tsel_q    <= (timer_prescale_sel_i == `PRESCALE_EXT);            // [RL11]
        end
    end

    assign rdata_o         = rdata_q;
    assign pin_b_o         = pb_o_q;
    assign pin_b_oe_n_o    = pb_oe_q;
    assign pin_c_o         = pc_o_q;
    assign pin_c_oe_n_o    = pc_oe_q;
    assign pin_d_o         = pd_o_q;
    assign pin_d_oe_n_o    = pd_oe_q;
    assign pin_e_o         = pe_o_q;
    assign pin_e_oe_n_o    = pe_oe_q;
    assign spi_clock_pin_o = sck_q;
    assign spi_mosi_in_o   = mosi_q;
    assign timer_ext_clk_o = timer_ext_clk_q;
    assign timer_ext_sel_o = tsel_q;

    // ==========================================================
    // checks
    sequence s_dir_c_write(v);
        wr_i && addr_i == `OFF_DIR_C && wdata_i[`BUS_CLK_OUT_BIT] == v;
    endsequence

    property p_analog_d_undriven;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        ##1 $past(ana_d) != 7'h00 |-> (pin_d_oe_n_o & $past(ana_d)) == $past(ana_d);
    endproperty
    a_analog_d_undriven: assert property (p_analog_d_undriven) else $error("analog d pin driven"); // [RL2]

    property p_clk_out_drive;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        s_dir_c_write(1'b1) ##1 1'b1 |=> !pin_c_oe_n_o[`PIN_C2];
    endproperty
    a_clk_out_drive: assert property (p_clk_out_drive) else $error("pin c2 not clock driven"); // [RL7]

    property p_c_read;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        rd_i && addr_i == `OFF_PORT_C_LATCH && dir_c_q[0] |=> rdata_o[0] == $past(lat_c_q[0]);
    endproperty
    a_c_read: assert property (p_c_read) else $error("port c read wrong"); // [RL5]

    property p_d_unused_zero;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        rd_i && addr_i == `OFF_PORT_D_LATCH |=> rdata_o[7] == 1'b0;
    endproperty
    a_d_unused_zero: assert property (p_d_unused_zero) else $error("port d bit 7 set"); // [RL19]

    property p_e_read;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        rd_i && addr_i == `OFF_PORT_E_LATCH && dir_e_q[3] |=> rdata_o[3] == $past(lat_e_q[3]);
    endproperty
    a_e_read: assert property (p_e_read) else $error("port e read wrong"); // [RL18]

    // any converter-owned input bit of port b must read back as zero
    property p_analog_b_read_zero;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        rd_i && addr_i == `OFF_PORT_B_LATCH |=> (rdata_o & $past(ana_b & ~dir_b_q)) == 8'h00;
    endproperty
    a_analog_b_read_zero: assert property (p_analog_b_read_zero) else $error("analog b read"); // [RL1]

    property p_sck_slave;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        spi_on_i && !spi_master_i |=> pin_e_oe_n_o[`PIN_E_SCK];
    endproperty
    a_sck_slave: assert property (p_sck_slave) else $error("sck driven as slave"); // [RL14]

    property p_dir_c_drive;
        @(posedge sys_clk_i) disable iff (!rst_n_i)
        dir_c_q[0] |=> !pin_c_oe_n_o[0] ##1 1'b1;
    endproperty
    a_dir_c_drive: assert property (p_dir_c_drive) else $error("port c0 not driven"); // [RL4]
endmodule : shared_gpio_ports

// File: design/gpio_defines.svh
// register offsets, field positions and reset values of the shared gpio ports
`ifndef GPIO_DEFINES_SVH
`define GPIO_DEFINES_SVH
// ==========================================================
// register map
`define OFF_PORT_B_LATCH 8'h01
`define OFF_PORT_C_LATCH 8'h02
`define OFF_PORT_D_LATCH 8'h03
`define OFF_DIR_B        8'h05
`define OFF_DIR_C        8'h06
`define OFF_DIR_D        8'h07
`define OFF_PORT_E_LATCH 8'h08
`define OFF_DIR_E        8'h0c
`define OFF_CTRL         8'h10
// ==========================================================
// fields
`define BUS_CLK_OUT_BIT  7
`define PORT_C_MASK      8'h1f
`define PORT_D_MASK      8'h7f
`define DIR_C_MASK       8'h9f
`define PIN_C2           2
`define PIN_D6           6
`define PIN_E_SCK        7
`define PIN_E_MOSI       6
`define CHAN_SEL_D_BASE  5'h08
`define CHAN_SEL_NONE    5'h1f
`define PRESCALE_EXT     3'h7
`define CTRL_RESET       8'h1f
`endif

// File: design/gpio_pkg.sv
// types shared by the shared gpio port files
package gpio_pkg;
    typedef logic [7:0] byte_t;
    typedef enum logic [1:0] {
        SRC_LATCH,
        SRC_PIN,
        SRC_ZERO
    } read_src_t;
endpackage : gpio_pkg

// File: design/pin_sync.sv
// two flip-flop synchroniser for a group of pin levels
`timescale 1ns/100ps
module pin_sync #(
    parameter int W = 8
) (
    input  wire logic         sys_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);
    logic [W-1:0] meta_q;
    logic [W-1:0] meta_d;
    logic [W-1:0] sync_q;
    logic [W-1:0] sync_d;

    always_comb begin
        meta_d = async_i;
        sync_d = meta_q;
    end

    always_ff @(posedge sys_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign sync_o = sync_q;
endmodule : pin_sync

// File: design/port_bit_mux.sv
// read and drive selection for one port of up to eight pins
`timescale 1ns/100ps
module port_bit_mux #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] latch_i,
    input  wire logic [W-1:0] dir_i,
    input  wire logic [W-1:0] pin_i,
    input  wire logic [W-1:0] analog_i,
    output logic      [W-1:0] rd_o,
    output logic      [W-1:0] drive_o
);
    always_comb begin
        for (int i = 0; i < W; i++) begin
            // analog bits read zero as inputs, the latch as outputs
            if (dir_i[i]) begin
                rd_o[i] = latch_i[i];
            end else if (analog_i[i]) begin
                rd_o[i] = 1'b0;
            end else begin
                rd_o[i] = pin_i[i];
            end
            // an analog pin is never driven whatever its direction bit
            drive_o[i] = dir_i[i] & ~analog_i[i];
        end
    end
endmodule : port_bit_mux

// File: dv/gpio_pins_model.sv
// pin side partner: resolves each shared pin from device drive and outside drive
`timescale 1ns/100ps
module gpio_pins_model (
    input  wire logic [7:0] drv_b_i,
    input  wire logic [7:0] oe_n_b_i,
    input  wire logic [7:0] ext_b_i,
    input  wire logic [4:0] drv_c_i,
    input  wire logic [4:0] oe_n_c_i,
    input  wire logic [4:0] ext_c_i,
    input  wire logic [6:0] drv_d_i,
    input  wire logic [6:0] oe_n_d_i,
    input  wire logic [6:0] ext_d_i,
    input  wire logic [7:0] drv_e_i,
    input  wire logic [7:0] oe_n_e_i,
    input  wire logic [7:0] ext_e_i,
    output logic      [7:0] lvl_b_o,
    output logic      [4:0] lvl_c_o,
    output logic      [6:0] lvl_d_o,
    output logic      [7:0] lvl_e_o
);
    // ==========================================================
    // wire level
    // outside drivers are weak: a driving device pin always wins, so a missing
    // enable shows up as the outside value instead of a silent match
    assign lvl_b_o = (~oe_n_b_i & drv_b_i) | (oe_n_b_i & ext_b_i);
    assign lvl_c_o = (~oe_n_c_i & drv_c_i) | (oe_n_c_i & ext_c_i);
    assign lvl_d_o = (~oe_n_d_i & drv_d_i) | (oe_n_d_i & ext_d_i);
    assign lvl_e_o = (~oe_n_e_i & drv_e_i) | (oe_n_e_i & ext_e_i);
endmodule : gpio_pins_model

// File: dv/shared_gpio_ports_tb_top.sv
// self-checking bench for the shared gpio ports
`timescale 1ns/100ps
`include "gpio_defines.svh"
module shared_gpio_ports_tb_top;
    import gpio_pkg::*;
    logic       sys_clk_i;
    logic       rst_n_i;
    logic [7:0] addr_i;
    logic [7:0] wdata_i;
    logic       wr_i;
    logic       rd_i;
    logic [7:0] rdata_o;
    logic [7:0] pin_b_i, pin_b_o, pin_b_oe_n_o, ext_b;
    logic [4:0] pin_c_i, pin_c_o, pin_c_oe_n_o, ext_c;
    logic [6:0] pin_d_i, pin_d_o, pin_d_oe_n_o, ext_d;
    logic [7:0] pin_e_i, pin_e_o, pin_e_oe_n_o, ext_e;
    logic       bus_clk_en_i, spi_on_i, spi_master_i, spi_sck_out_i, spi_mosi_out_i;
    logic [2:0] timer_prescale_sel_i;
    logic       spi_clock_pin_o, spi_mosi_in_o, timer_ext_clk_o, timer_ext_sel_o;
    logic       prev_clk;
    int         err_count;
    int         total_checks;
    int         cycles;

    // ==========================================================
    // clock, design and pins
    always #4 sys_clk_i = ~sys_clk_i;

    shared_gpio_ports i_shared_gpio_ports (
        .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
        .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .pin_b_i(pin_b_i), .pin_b_o(pin_b_o), .pin_b_oe_n_o(pin_b_oe_n_o),
        .pin_c_i(pin_c_i), .pin_c_o(pin_c_o), .pin_c_oe_n_o(pin_c_oe_n_o),
        .pin_d_i(pin_d_i), .pin_d_o(pin_d_o), .pin_d_oe_n_o(pin_d_oe_n_o),
        .pin_e_i(pin_e_i), .pin_e_o(pin_e_o), .pin_e_oe_n_o(pin_e_oe_n_o),
        .bus_clk_en_i(bus_clk_en_i), .timer_prescale_sel_i(timer_prescale_sel_i),
        .spi_on_i(spi_on_i), .spi_master_i(spi_master_i), .spi_sck_out_i(spi_sck_out_i),
        .spi_mosi_out_i(spi_mosi_out_i), .spi_clock_pin_o(spi_clock_pin_o),
        .spi_mosi_in_o(spi_mosi_in_o), .timer_ext_clk_o(timer_ext_clk_o),
        .timer_ext_sel_o(timer_ext_sel_o));

    gpio_pins_model i_gpio_pins_model (
        .drv_b_i(pin_b_o), .oe_n_b_i(pin_b_oe_n_o), .ext_b_i(ext_b),
        .drv_c_i(pin_c_o), .oe_n_c_i(pin_c_oe_n_o), .ext_c_i(ext_c),
        .drv_d_i(pin_d_o), .oe_n_d_i(pin_d_oe_n_o), .ext_d_i(ext_d),
        .drv_e_i(pin_e_o), .oe_n_e_i(pin_e_oe_n_o), .ext_e_i(ext_e),
        .lvl_b_o(pin_b_i), .lvl_c_o(pin_c_i), .lvl_d_o(pin_d_i), .lvl_e_o(pin_e_i));

    // ==========================================================
    // access and compare tasks
    task check(input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wr_i    <= 1'b1;
        @(posedge sys_clk_i);
        wr_i    <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, input logic [7:0] exp);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge sys_clk_i);
        rd_i   <= 1'b0;
        #1;
        check(rdata_o, exp);
    endtask : rd

    // covers the pin register stage plus the two synchroniser flops
    task settle;
        repeat (4) @(posedge sys_clk_i);
        #1;
    endtask : settle

    task end_of_test;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test

    // ==========================================================
    // timeout: the full sequence needs well under 1000 cycles
    always @(posedge sys_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            err_count++;
            end_of_test;
        end
    end

    // ==========================================================
    // sequence
    initial begin
        sys_clk_i = 0; rst_n_i = 0; addr_i = 8'h00; wdata_i = 8'h00; wr_i = 0; rd_i = 0;
        ext_b = 8'hff; ext_c = 5'h0a; ext_d = 7'h7f; ext_e = 8'hff;
        bus_clk_en_i = 1; timer_prescale_sel_i = 3'h0; spi_on_i = 0; spi_master_i = 0;
        spi_sck_out_i = 0; spi_mosi_out_i = 1;
        err_count = 0; total_checks = 0; cycles = 0;
        repeat (20) @(posedge sys_clk_i);
        rst_n_i <= 1'b1;
        settle();
        check({3'h0, pin_c_oe_n_o}, 8'h1f);
        check({1'h0, pin_d_oe_n_o}, 8'h7f);
        rd(`OFF_DIR_C, 8'h00);
        rd(`OFF_DIR_D, 8'h00);
        rd(`OFF_CTRL, `CTRL_RESET);
        rd(8'h20, 8'h00);
        // port c: latch written first so the pin never shows a stale value
        wr(`OFF_PORT_C_LATCH, 8'h15);
        settle();
        check({3'h0, pin_c_oe_n_o}, 8'h1f);
        rd(`OFF_PORT_C_LATCH, 8'h0a);
        wr(`OFF_DIR_C, 8'h03);
        settle();
        check({3'h0, pin_c_oe_n_o}, 8'h1c);
        check({6'h0, pin_c_o[1:0]}, 8'h01);
        rd(`OFF_PORT_C_LATCH, 8'h09);
        wr(`OFF_PORT_C_LATCH, 8'hff);
        wr(`OFF_DIR_C, 8'hff);
        rd(`OFF_DIR_C, 8'h9f);
        rd(`OFF_PORT_C_LATCH, 8'h1f);
        // bus clock mode: pin c2 toggles whatever its direction bit says
        ext_c <= 5'h00;
        wr(`OFF_DIR_C, 8'h80);
        settle();
        check({3'h0, pin_c_oe_n_o}, 8'h1b);
        prev_clk = pin_c_o[2];
        @(posedge sys_clk_i);
        #1;
        check({7'h0, pin_c_o[2]}, {7'h0, ~prev_clk});
        rd(`OFF_PORT_C_LATCH, 8'h04);
        wr(`OFF_DIR_C, 8'h00);
        settle();
        check({3'h0, pin_c_oe_n_o}, 8'h1f);
        // port d shared with converter channel 11
        wr(`OFF_PORT_D_LATCH, 8'h55);
        wr(`OFF_DIR_D, 8'h7f);
        settle();
        check({1'h0, pin_d_oe_n_o}, 8'h00);
        check({1'h0, pin_d_o}, 8'h55);
        wr(`OFF_CTRL, 8'h0b);
        settle();
        check({1'h0, pin_d_oe_n_o}, 8'h08);
        rd(`OFF_PORT_D_LATCH, 8'h55);
        wr(`OFF_DIR_D, 8'h00);
        settle();
        rd(`OFF_PORT_D_LATCH, 8'h77);
        // port b shared with converter channel 5
        wr(`OFF_PORT_B_LATCH, 8'h00);
        wr(`OFF_CTRL, 8'h05);
        settle();
        rd(`OFF_PORT_B_LATCH, 8'hdf);
        wr(`OFF_DIR_B, 8'hff);
        settle();
        check(pin_b_oe_n_o, 8'h20);
        rd(`OFF_PORT_B_LATCH, 8'h00);
        wr(`OFF_CTRL, 8'h1f);
        settle();
        rd(`OFF_PORT_D_LATCH, 8'h7f);
        // timer clock from pin d6; channel 14 stays deselected meanwhile
        @(posedge sys_clk_i);
        timer_prescale_sel_i <= `PRESCALE_EXT;
        ext_d <= 7'h40;
        settle();
        check({7'h0, timer_ext_sel_o}, 8'h01);
        check({7'h0, timer_ext_clk_o}, 8'h01);
        ext_d <= 7'h00;
        settle();
        check({7'h0, timer_ext_clk_o}, 8'h00);
        @(posedge sys_clk_i);
        timer_prescale_sel_i <= 3'h0;
        settle();
        check({7'h0, timer_ext_sel_o}, 8'h00);
        // port e and the spi pins
        wr(`OFF_PORT_E_LATCH, 8'ha5);
        wr(`OFF_DIR_E, 8'h0f);
        settle();
        check(pin_e_oe_n_o, 8'hf0);
        check({4'h0, pin_e_o[3:0]}, 8'h05);
        rd(`OFF_PORT_E_LATCH, 8'hf5);
        @(posedge sys_clk_i);
        spi_on_i <= 1'b1;
        spi_master_i <= 1'b1;
        settle();
        check({6'h0, pin_e_oe_n_o[7:6]}, 8'h00);
        // spi drives 01, the latch holds 10, so the hand-back below is visible
        check({6'h0, pin_e_o[7:6]}, 8'h01);
        @(posedge sys_clk_i);
        spi_master_i <= 1'b0;
        ext_e <= 8'h80;
        settle();
        check({6'h0, pin_e_oe_n_o[7:6]}, 8'h03);
        check({6'h0, spi_clock_pin_o, spi_mosi_in_o}, 8'h02);
        ext_e <= 8'h40;
        settle();
        check({6'h0, spi_clock_pin_o, spi_mosi_in_o}, 8'h01);
        @(posedge sys_clk_i);
        spi_on_i <= 1'b0;
        wr(`OFF_DIR_E, 8'hc0);
        settle();
        check({6'h0, pin_e_oe_n_o[7:6]}, 8'h00);
        check({6'h0, pin_e_o[7:6]}, 8'h02);
        end_of_test;
    end
endmodule : shared_gpio_ports_tb_top
